/* File: logic/event_capture_timer.v */
// Overview of operation
// [RULE_01] software loads count, advances per selected clock
// [RULE_02] overflow at FF reloads or restarts zero
// [RULE_03] overflow sets irq flag, software clears
// [RULE_04] software selects event clock and pin
// [RULE_05] event mode counts chosen edges
// [RULE_06] source keeps two cycles fall-to-rise
// [RULE_07] mode two selects four output modes
// [RULE_08] reset drives timer output low
// [RULE_09] capture copies count, flags, clears counter
// [RULE_10] trigger or overflow while status sets error
// [RULE_11] capture flags clear on reset or zero write
// [RULE_12] capture mode frees pin, clears counter
// [RULE_13] mode one write effective second cycle later
// [RULE_14] software uses prescaler clock for capture
// [RULE_15] captured nibbles readable in either order
// [RULE_16] mode one four-bit write-only, resets zero
// [RULE_17] mode two four-bit read-write, resets zero
// [RULE_18] edge field: none, fall, rise, both
// [RULE_19] pwm valid after overflow following update
// [RULE_20] toggle, fixed levels, pwm duty from load
`timescale 1ns/100ps
`include "event_capture_timer_map.vh"

module event_capture_timer (
    // clock and reset
    input wire CLK_SYS,
    input wire RST,
    // axi4-lite write address
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    // axi4-lite write data
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    // axi4-lite write response
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // axi4-lite read address
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    // axi4-lite read data
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // pins
    input wire EVENT_TRIGGER_INPUT,
    output wire TIMER_OUTPUT_PIN,
    output wire TIMER_OUTPUT_EN,
    output wire TIMER_IRQ_FLAG
);

    // ****************************************
    // address decode helpers
    // ****************************************
    function hit;
        input [31:0] addr;
        input [7:0] idx;
        begin
            hit = (addr[31:10] == 22'h0) && (addr[9:2] == idx);
        end
    endfunction

    function mapped;
        input [31:0] addr;
        begin
            mapped = hit(addr, `IDX_IRQ_FLAGS) || hit(addr, `IDX_MODE_ONE) ||
                hit(addr, `IDX_LOAD_LOW) || hit(addr, `IDX_LOAD_HIGH) ||
                hit(addr, `IDX_MODE_TWO) || hit(addr, `IDX_CAPTURE_FLAGS) ||
                hit(addr, `IDX_PIN_FUNC) || hit(addr, `IDX_EDGE_SEL);
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg aw_held_reg;
    reg [31:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg w_lane0_reg;
    reg [3:0] mode_one_reg;
    reg [3:0] mode_one_pend_reg;
    reg [1:0] mode_one_wait_reg;
    reg [3:0] mode_two_reg;
    reg [3:0] pin_func_reg;
    reg [3:0] edge_sel_reg;
    reg [3:0] load_low_reg;
    reg [3:0] load_high_reg;
    reg [7:0] count_reg;
    reg [7:0] capture_reg;
    reg [3:0] read_upper_reg;
    reg [7:0] duty_reg;
    reg irq_flag_reg;
    reg cap_status_reg;
    reg cap_error_reg;
    reg out_reg;
    reg event_prev_reg;
    reg [10:0] presc_reg;
    reg [7:0] cyc_reg;

    // ****************************************
    // write channel
    // ****************************************
    wire aw_take = S_AXI_AWVALID && !aw_held_reg && !S_AXI_BVALID;
    wire w_take = S_AXI_WVALID && !w_held_reg && !S_AXI_BVALID;
    assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held_reg && !S_AXI_BVALID;
    wire do_write = aw_held_reg && w_held_reg;
    wire [3:0] wnib = w_data_reg[3:0];
    wire wr_mode_one = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_MODE_ONE);
    wire wr_load_low = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_LOAD_LOW);
    wire wr_load_high = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_LOAD_HIGH);
    wire wr_mode_two = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_MODE_TWO);
    wire wr_irq = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_IRQ_FLAGS);
    wire wr_cap = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_CAPTURE_FLAGS);
    wire wr_pin = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_PIN_FUNC);
    wire wr_edge = do_write && w_lane0_reg && hit(aw_addr_reg, `IDX_EDGE_SEL);

    always @(posedge CLK_SYS) begin
        if (RST) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_lane0_reg <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_lane0_reg <= S_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire ar_take = S_AXI_ARVALID && !S_AXI_RVALID;
    wire capture_mode = mode_two_reg[`M2_CAPTURE_BIT];
    // in capture mode both nibbles come from the frozen capture word
    wire [7:0] read_word = capture_mode ? capture_reg : count_reg; // RULE_15

    always @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_OKAY;
            read_upper_reg <= `RST_NIBBLE;
        end else begin
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
                S_AXI_RDATA <= 32'h0000_0000;
                if (hit(S_AXI_ARADDR, `IDX_LOAD_LOW)) begin
                    S_AXI_RDATA[3:0] <= read_word[3:0];
                    read_upper_reg <= count_reg[7:4];
                end else if (hit(S_AXI_ARADDR, `IDX_LOAD_HIGH)) begin
                    // free counting: upper nibble as it stood at the low read
                    S_AXI_RDATA[3:0] <= capture_mode ? capture_reg[7:4] : read_upper_reg; // RULE_15
                end else if (hit(S_AXI_ARADDR, `IDX_MODE_TWO)) begin
                    S_AXI_RDATA[3:0] <= mode_two_reg; // RULE_17
                end else if (hit(S_AXI_ARADDR, `IDX_IRQ_FLAGS)) begin
                    S_AXI_RDATA[`IRQ_TIMER_BIT] <= irq_flag_reg;
                end else if (hit(S_AXI_ARADDR, `IDX_CAPTURE_FLAGS)) begin
                    S_AXI_RDATA[`CAP_STATUS_BIT] <= cap_status_reg;
                    S_AXI_RDATA[`CAP_ERROR_BIT] <= cap_error_reg;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ****************************************
    // control registers; mode one takes over late
    // ****************************************
    localparam [31:0] mode_one_lag = `MODE_ONE_DELAY - 1;
    always @(posedge CLK_SYS) begin
        if (RST) begin
            mode_one_reg <= `RST_NIBBLE; // RULE_16
            mode_one_pend_reg <= `RST_NIBBLE;
            mode_one_wait_reg <= 2'h0;
        end else if (wr_mode_one) begin
            mode_one_pend_reg <= wnib;
            mode_one_wait_reg <= mode_one_lag[1:0]; // RULE_13
        end else if (mode_one_wait_reg != 2'h0) begin
            mode_one_wait_reg <= mode_one_wait_reg - 2'h1;
            if (mode_one_wait_reg == 2'h1) begin
                mode_one_reg <= mode_one_pend_reg; // RULE_13
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            mode_two_reg <= `RST_NIBBLE; // RULE_17
            pin_func_reg <= `RST_NIBBLE;
            edge_sel_reg <= `RST_NIBBLE;
            load_low_reg <= `RST_NIBBLE;
            load_high_reg <= `RST_NIBBLE;
        end else begin
            if (wr_mode_two) begin
                mode_two_reg <= wnib;
            end
            if (wr_pin) begin
                pin_func_reg <= wnib;
            end
            if (wr_edge) begin
                edge_sel_reg <= wnib;
            end
            if (wr_load_low) begin
                load_low_reg <= wnib;
            end
            if (wr_load_high) begin
                load_high_reg <= wnib;
            end
        end
    end

    // ****************************************
    // clock source: prescaler or event edges
    // ****************************************
    localparam [31:0] cyc_last = `CYC_CLKS - 1;
    wire cyc_tick = (cyc_reg == cyc_last[7:0]);
    always @(posedge CLK_SYS) begin
        if (RST) begin
            cyc_reg <= 8'h00;
            presc_reg <= 11'h000;
            event_prev_reg <= 1'b0;
        end else begin
            cyc_reg <= cyc_tick ? 8'h00 : cyc_reg + 8'h01;
            if (cyc_tick) begin
                presc_reg <= presc_reg + 11'h001;
            end
            event_prev_reg <= EVENT_TRIGGER_INPUT;
        end
    end

    // ratios 2048,1024,512,128,32,8,4 instruction cycles
    reg presc_tick;
    always @* begin
        case (mode_one_reg[`M1_CLKSEL_MSB:`M1_CLKSEL_LSB])
            3'h0: presc_tick = &presc_reg[10:0];
            3'h1: presc_tick = &presc_reg[9:0];
            3'h2: presc_tick = &presc_reg[8:0];
            3'h3: presc_tick = &presc_reg[6:0];
            3'h4: presc_tick = &presc_reg[4:0];
            3'h5: presc_tick = &presc_reg[2:0];
            3'h6: presc_tick = &presc_reg[1:0];
            default: presc_tick = 1'b0;
        endcase
        presc_tick = presc_tick && cyc_tick;
    end

    wire [1:0] edge_mode = edge_sel_reg[`ES_EVENT_MSB:`ES_EVENT_LSB];
    wire rise = EVENT_TRIGGER_INPUT && !event_prev_reg;
    wire fall = !EVENT_TRIGGER_INPUT && event_prev_reg;
    // pin stays a port until its event function is selected
    wire event_edge = pin_func_reg[`PF_EVENT_BIT] && (
        (edge_mode == `EDGE_FALL && fall) ||
        (edge_mode == `EDGE_RISE && rise) ||
        (edge_mode == `EDGE_BOTH && (rise || fall))); // RULE_18
    wire event_clk = (mode_one_reg[`M1_CLKSEL_MSB:`M1_CLKSEL_LSB] == `CLKSEL_EVENT);
    wire count_tick = event_clk ? (event_edge && !capture_mode) : presc_tick; // RULE_05
    wire trigger = capture_mode && event_edge;
    wire overflow = count_tick && (count_reg == `COUNT_MAX); // RULE_02
    wire [7:0] load_value = {load_high_reg, load_low_reg};
    wire capture_enter = wr_mode_two && wnib[`M2_CAPTURE_BIT] && !capture_mode;

    // ****************************************
    // counter and capture
    // ****************************************
    always @(posedge CLK_SYS) begin
        if (RST) begin
            count_reg <= `RST_COUNT;
            capture_reg <= `RST_COUNT;
            duty_reg <= `RST_COUNT;
        end else begin
            if (capture_enter) begin
                count_reg <= `RST_COUNT; // RULE_12
            end else if (trigger) begin
                capture_reg <= count_reg; // RULE_09
                count_reg <= `RST_COUNT;
            end else if (wr_load_high) begin
                // high nibble write moves the whole word into the counter
                count_reg <= {wnib, load_low_reg}; // RULE_01
            end else if (overflow) begin
                count_reg <= mode_one_reg[`M1_RELOAD_BIT] ? load_value : `RST_COUNT; // RULE_02
            end else if (count_tick) begin
                count_reg <= count_reg + 8'h01; // RULE_01
            end
            // duty waits for an overflow, so a half-written period never shows
            if (overflow) begin
                duty_reg <= load_value; // RULE_20
            end
        end
    end

    // ****************************************
    // flags: a set in the clearing cycle wins
    // ****************************************
    always @(posedge CLK_SYS) begin
        if (RST) begin
            irq_flag_reg <= 1'b0;
            cap_status_reg <= 1'b0;
            cap_error_reg <= 1'b0;
        end else begin
            if (overflow || trigger) begin
                irq_flag_reg <= 1'b1; // RULE_03
            end else if (wr_irq && !wnib[`IRQ_TIMER_BIT]) begin
                irq_flag_reg <= 1'b0; // RULE_03
            end
            if (trigger) begin
                cap_status_reg <= 1'b1; // RULE_09
            end else if (wr_cap && !wnib[`CAP_STATUS_BIT]) begin
                cap_status_reg <= 1'b0; // RULE_11
            end
            if (cap_status_reg && (trigger || (capture_mode && overflow))) begin
                cap_error_reg <= 1'b1; // RULE_10
            end else if (wr_cap && !wnib[`CAP_ERROR_BIT]) begin
                cap_error_reg <= 1'b0; // RULE_11
            end
        end
    end

    // ****************************************
    // timer output
    // ****************************************
    wire [1:0] out_mode = mode_two_reg[`M2_OUTMODE_MSB:`M2_OUTMODE_LSB];
    always @(posedge CLK_SYS) begin
        if (RST) begin
            out_reg <= 1'b0; // RULE_08
        end else begin
            case (out_mode)
                `OUT_TOGGLE: out_reg <= out_reg ^ overflow; // RULE_20
                `OUT_LOW: out_reg <= 1'b0; // RULE_20
                `OUT_HIGH: out_reg <= 1'b1; // RULE_20
                default: out_reg <= (count_reg < duty_reg); // RULE_20
            endcase
        end
    end

    assign TIMER_OUTPUT_PIN = out_reg;
    assign TIMER_OUTPUT_EN = mode_two_reg[`M2_OUT_EN_BIT] && !capture_mode; // RULE_07 RULE_12
    assign TIMER_IRQ_FLAG = irq_flag_reg;

endmodule

/* File: logic/event_capture_timer_map.vh */
`ifndef EVENT_CAPTURE_TIMER_MAP_VH
`define EVENT_CAPTURE_TIMER_MAP_VH

// register indices; byte address is four times the index
`define IDX_IRQ_FLAGS 8'h03
`define IDX_MODE_ONE 8'h10
`define IDX_LOAD_LOW 8'h11
`define IDX_LOAD_HIGH 8'h12
`define IDX_MODE_TWO 8'h15
`define IDX_CAPTURE_FLAGS 8'h21
`define IDX_PIN_FUNC 8'h25
`define IDX_EDGE_SEL 8'h27

// timer_mode_one fields
`define M1_RELOAD_BIT 3
`define M1_CLKSEL_MSB 2
`define M1_CLKSEL_LSB 0
`define CLKSEL_EVENT 3'h7

// timer_mode_two fields
`define M2_CAPTURE_BIT 3
`define M2_OUT_EN_BIT 2
`define M2_OUTMODE_MSB 1
`define M2_OUTMODE_LSB 0
`define OUT_TOGGLE 2'h0
`define OUT_LOW 2'h1
`define OUT_HIGH 2'h2
`define OUT_PWM 2'h3

// pin_function_select and edge_select_two fields
`define PF_EVENT_BIT 1
`define ES_EVENT_MSB 3
`define ES_EVENT_LSB 2
`define EDGE_NONE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3

// flag bit positions
`define IRQ_TIMER_BIT 0
`define CAP_STATUS_BIT 0
`define CAP_ERROR_BIT 1

// reset values and counter maximum
`define RST_NIBBLE 4'h0
`define RST_COUNT 8'h00
`define COUNT_MAX 8'hFF

// timing: one instruction cycle in system clocks, mode_one write latency
`define CYC_CLKS 1
`define MODE_ONE_DELAY 2

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: verification/event_capture_timer_properties.sv */
`timescale 1ns/100ps
module event_capture_timer_properties (
    // clock and reset
    input logic CLK_SYS,
    input logic RST,
    // bus handshakes
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic S_AXI_BVALID,
    input logic S_AXI_BREADY,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic S_AXI_RVALID,
    input logic S_AXI_RREADY,
    // pins
    input logic TIMER_OUTPUT_PIN,
    input logic TIMER_OUTPUT_EN,
    input logic TIMER_IRQ_FLAG
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic hs;
    // any write handshake; registers only change on the edge after one
    assign hs = (S_AXI_AWVALID && S_AXI_AWREADY) || (S_AXI_WVALID && S_AXI_WREADY);

    chk_out_reset: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        $fell(RST) |-> !TIMER_OUTPUT_PIN && !TIMER_IRQ_FLAG) else $error("pin high after reset");
    chk_irq_sticky: assert property (TIMER_IRQ_FLAG && !$past(hs) |=> TIMER_IRQ_FLAG)
        else $error("irq flag dropped without a write");
    chk_en_steady: assert property (!$past(hs) |=> $stable(TIMER_OUTPUT_EN))
        else $error("pin function changed without a write");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response not held");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data not held");
    chk_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken during answer");
    chk_b_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken during response");
    chk_rdata_nibble: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h000_0000)
        else $error("read data wider than a nibble");
endmodule

bind event_capture_timer event_capture_timer_properties chk (
    .CLK_SYS(CLK_SYS), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_EN(TIMER_OUTPUT_EN),
    .TIMER_IRQ_FLAG(TIMER_IRQ_FLAG)
);

/* File: verification/event_source_model.sv */
`timescale 1ns/100ps
module event_source_model (
    // clock
    input logic clk,
    // event line
    output logic evt
);
    initial evt = 1'b0;
    // each pulse gives one rise and one fall, moved right after an edge
    task automatic pulses(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            evt <= 1'b1;
            repeat (hi) @(posedge clk);
            evt <= 1'b0;
            // low time never under two cycles, else double-edge counting loses edges
            repeat ((lo < 2) ? 2 : lo) @(posedge clk);
        end
    endtask
endmodule

/* File: verification/event_capture_timer_tb.sv */
`timescale 1ns/100ps
`include "event_capture_timer_map.vh"
module event_capture_timer_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, pin, pin_en, irq, evt;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total = 0, checks_done = 0, seed = 78011;
    always #2 clk_sys = ~clk_sys;

    event_capture_timer DUT (
        .CLK_SYS(clk_sys), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .EVENT_TRIGGER_INPUT(evt), .TIMER_OUTPUT_PIN(pin), .TIMER_OUTPUT_EN(pin_en),
        .TIMER_IRQ_FLAG(irq)
    );
    event_source_model src (.clk(clk_sys), .evt(evt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 300) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [3:0] d, input logic [1:0] er);
        int n;
        bit a;
        bit w;
        a = 0;
        w = 0;
        @(posedge clk_sys);
        awaddr <= {24'h00_0000, idx} << 2;
        wdata <= {28'h000_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 300 && !(a && w); n++) begin
            @(posedge clk_sys);
            if (!a && awready)
                a = 1;
            if (!w && wready)
                w = 1;
            if (a)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
        end
        tmo(n);
        for (n = 0; n < 300; n++) begin
            @(posedge clk_sys);
            if (bvalid)
                break;
        end
        tmo(n);
        bready <= 1'b0;
        check(bresp, er);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [3:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        araddr <= {24'h00_0000, idx} << 2;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_sys);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        tmo(n);
        rready <= 1'b0;
        d = rdata[3:0];
        check(rresp, er);
    endtask

    initial begin
        int r, e, k, np, edges, ref_cnt, ref_load;
        bit ref_ovf;
        logic [3:0] lo, hi;
        logic p;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        // ************************************************************
        // reset state and refused accesses
        // ************************************************************
        check(pin, 0);
        rd(`IDX_MODE_TWO, lo, `RESP_OKAY);
        check(lo, 0);
        rd(`IDX_MODE_ONE, lo, `RESP_OKAY);
        check(lo, 0);
        rd(8'h3F, lo, `RESP_SLVERR);
        check(lo, 0);
        wr(8'h3F, 4'h1, `RESP_SLVERR);
        // ************************************************************
        // event counting, every edge code, free and reload
        // ************************************************************
        wr(`IDX_PIN_FUNC, 4'h2, `RESP_OKAY);
        for (r = 0; r < 2; r++)
            for (e = 0; e < 4; e++) begin
                wr(`IDX_EDGE_SEL, 4'(e << 2), `RESP_OKAY);
                wr(`IDX_MODE_ONE, {r[0], `CLKSEL_EVENT}, `RESP_OKAY);
                // load only once the new mode has settled
                repeat (4) @(posedge clk_sys);
                ref_load = 240 + ($random(seed) & 15);
                wr(`IDX_LOAD_LOW, 4'(ref_load), `RESP_OKAY);
                wr(`IDX_LOAD_HIGH, 4'(ref_load >> 4), `RESP_OKAY);
                np = 6 + ($random(seed) & 7);
                src.pulses(np, 1 + (e & 1), 2 + r);
                edges = (e == 0) ? 0 : (e == 3) ? 2 * np : np;
                ref_cnt = ref_load;
                ref_ovf = 0;
                for (k = 0; k < edges; k++) begin
                    ref_ovf = ref_ovf | (ref_cnt == 255);
                    ref_cnt = (ref_cnt == 255) ? (r ? ref_load : 0) : ref_cnt + 1;
                end
                repeat (3) @(posedge clk_sys);
                rd(`IDX_LOAD_LOW, lo, `RESP_OKAY);
                rd(`IDX_LOAD_HIGH, hi, `RESP_OKAY);
                check({hi, lo}, ref_cnt);
                check(irq, ref_ovf);
                rd(`IDX_IRQ_FLAGS, lo, `RESP_OKAY);
                check(lo, {3'b000, ref_ovf});
                wr(`IDX_IRQ_FLAGS, 4'h0, `RESP_OKAY);
                check(irq, 0);
            end
        // ************************************************************
        // output modes: fixed levels, toggle, pwm
        // ************************************************************
        wr(`IDX_EDGE_SEL, 4'h8, `RESP_OKAY);
        wr(`IDX_MODE_ONE, 4'h7, `RESP_OKAY);
        for (k = 1; k < 3; k++) begin
            wr(`IDX_MODE_TWO, 4'(4 + k), `RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            check(pin_en, 1);
            check(pin, k - 1);
        end
        rd(`IDX_MODE_TWO, lo, `RESP_OKAY);
        check(lo, 4'h6);
        for (k = 0; k < 4; k += 3) begin
            wr(`IDX_MODE_TWO, 4'(4 + k), `RESP_OKAY);
            wr(`IDX_LOAD_LOW, 4'hF, `RESP_OKAY);
            wr(`IDX_LOAD_HIGH, 4'hF, `RESP_OKAY);
            p = pin;
            src.pulses(1, 1, 3);
            // toggle inverts; pwm after a free-run wrap gives 00 below duty FF
            check(pin, (k == 0) ? !p : 1'b1);
        end
        // ************************************************************
        // capture: value, read order, status and error flags, reset
        // ************************************************************
        wr(`IDX_MODE_ONE, 4'h6, `RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        wr(`IDX_MODE_TWO, 4'h8, `RESP_OKAY);
        check(pin_en, 0);
        wr(`IDX_IRQ_FLAGS, 4'h0, `RESP_OKAY);
        check(irq, 0);
        repeat (80) @(posedge clk_sys);
        src.pulses(1, 2, 2);
        rd(`IDX_LOAD_HIGH, hi, `RESP_OKAY);
        rd(`IDX_LOAD_LOW, lo, `RESP_OKAY);
        check({hi, lo} >= 19 && {hi, lo} <= 23, 1);
        rd(`IDX_LOAD_LOW, lo, `RESP_OKAY);
        rd(`IDX_LOAD_HIGH, hi, `RESP_OKAY);
        check({hi, lo} >= 19 && {hi, lo} <= 23, 1);
        check(irq, 1);
        rd(`IDX_CAPTURE_FLAGS, lo, `RESP_OKAY);
        check(lo, 4'h1);
        src.pulses(1, 2, 2);
        rd(`IDX_CAPTURE_FLAGS, lo, `RESP_OKAY);
        check(lo, 4'h3);
        wr(`IDX_CAPTURE_FLAGS, 4'h2, `RESP_OKAY);
        rd(`IDX_CAPTURE_FLAGS, lo, `RESP_OKAY);
        check(lo, 4'h2);
        wr(`IDX_MODE_TWO, 4'h6, `RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        check(pin, 1);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(pin, 0);
        check(irq, 0);
        rd(`IDX_CAPTURE_FLAGS, lo, `RESP_OKAY);
        check(lo, 0);
        rd(`IDX_MODE_TWO, lo, `RESP_OKAY);
        check(lo, 0);
        give_verdict();
    end
endmodule
